// file: inc/spc_pkg.sv
// constants and pin carriers of the serial port control
package spc_pkg;

  // ==========================================================
  // register indices on the control port
  localparam int REG_AW = 5;
  localparam logic [4:0] ADDR_PIN_CONTROL = 5'h00;
  localparam logic [4:0] ADDR_MC_ONE = 5'h01;
  localparam logic [4:0] ADDR_MC_TWO = 5'h02;
  localparam logic [4:0] ADDR_RATE_CFG_TWO = 5'h03;
  localparam logic [4:0] ADDR_FRAME_CFG = 5'h04;
  localparam logic [4:0] ADDR_CHAN_EN_BASE = 5'h08;
  localparam int CHAN_EN_COUNT = 12;

  // ==========================================================
  // pin_control fields
  localparam int PC_RX_GPIO_EN = 12;
  localparam int PC_TX_FS_DIR = 11;
  localparam int PC_RX_FS_DIR = 10;
  localparam int PC_TX_CLK_DIR = 9;
  localparam int PC_RX_CLK_DIR = 8;
  localparam int PC_SRC_EXTEND = 7;
  localparam int PC_CLKS_STATE = 6;
  localparam int PC_DX_STATE = 5;
  localparam int PC_DR_STATE = 4;
  localparam int PC_TX_FS_POL = 3;
  localparam int PC_RX_FS_POL = 2;
  localparam int PC_TX_CLK_POL = 1;
  localparam int PC_RX_CLK_POL = 0;
  localparam logic [15:0] PIN_CONTROL_MASK = 16'h1F8F;
  localparam logic [15:0] PIN_CONTROL_RESET = 16'h0000;

  // ==========================================================
  // multichannel, rate generator and frame fields
  localparam int MC_EXT_ENABLE = 9;
  localparam int MC_MULTI_ENABLE = 0;
  localparam logic [15:0] MC_MASK = 16'h0201;
  localparam logic [15:0] MC_RESET = 16'h0000;
  localparam int RG_SRC_SELECT = 13;
  localparam int RG_DIV_W = 8;
  localparam logic [15:0] RATE_CFG_MASK = 16'h20FF;
  localparam logic [15:0] RATE_CFG_RESET = 16'h2000;
  localparam int FC_WL_LSB = 0;
  localparam int FC_WORDS_LSB = 3;
  localparam int FC_TWO_PHASE = 10;
  localparam int FC_CLK_STOP = 11;
  localparam int FC_TX_EN = 12;
  localparam int FC_RX_EN = 13;
  localparam logic [15:0] FRAME_CFG_MASK = 16'h3FFF;
  localparam logic [15:0] FRAME_CFG_RESET = 16'h0000;
  localparam logic [15:0] CHAN_EN_RESET = 16'h0000;
  localparam int WORD_MAX = 32;

  // ==========================================================
  // pin carriers
  typedef struct packed {
    logic tx_bit_clock_pin;
    logic rx_bit_clock_pin;
    logic tx_fs;
    logic rx_fs;
    logic rx_data;
  } spc_pin_in_s;

  typedef struct packed {
    logic tx_bit_clock_pin;
    logic tx_bit_clock_pin_oe;
    logic rx_bit_clock_pin;
    logic rx_bit_clock_pin_oe;
    logic tx_fs;
    logic tx_fs_oe;
    logic rx_fs;
    logic rx_fs_oe;
    logic tx_data;
    logic tx_data_oe;
  } spc_pin_out_s;

endpackage : spc_pkg

// file: rtl/spc_serial_port_ctrl.sv
// buffered serial port control block
//
// Operation
// - extended mode bit clear gives legacy selection of up to 32 channels.
// - bit 9 of each multichannel register enables 128-channel selection.
// - extended mode takes channel enables from the first eight of the twelve shared enable registers.
// - clock stop mode uses one phase and exactly one word per frame.
// - word length selectable as 8, 12, 16, 20, 24 or 32 bits.
// - in clock stop mode transmitter and receiver act as one unit.
// - rate generator can follow an external clock on either bit-clock pin.
// - extend bit and select bit pick reserved, cpu clock, rx pin, tx pin.
// - a bit-clock pin used as rate input has its driver switched off.
// - with the cpu clock as rate source, both clock direction bits set run tx and rx from generator output.
// - rx pin as rate input means generated clock leaves only on tx pin.
// - pin control bits 12..0 hold enable, directions, extend, status, polarity.
// - logic is static and works at arbitrarily slow pin clocks.
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// word fifo in the transmit path
module spc_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 8
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic in_valid_i,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic in_ready_o,
  output logic out_valid_o,
  output logic [WIDTH-1:0] out_data_o,
  input wire logic out_ready_i
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_ptr_q;
  logic [AW-1:0] rd_ptr_q;
  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;
  logic push;
  logic pop;

  // handshakes and next occupancy
  assign push = in_valid_i & in_ready_o;
  assign pop = out_valid_o & out_ready_i;
  always_comb
  begin
    cnt_d = cnt_q;
    if (push && !pop)
      cnt_d = cnt_q + CW'(1);
    else if (pop && !push)
      cnt_d = cnt_q - CW'(1);
  end

  // storage
  always_ff @(posedge mclk_i)
  begin
    if (push)
      mem_q[wr_ptr_q] <= in_data_i;
  end

  // pointers wrap at depth
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
    end
    else
    begin
      if (push)
        wr_ptr_q <= (wr_ptr_q == AW'(DEPTH - 1)) ? '0 : wr_ptr_q + AW'(1);
      if (pop)
        rd_ptr_q <= (rd_ptr_q == AW'(DEPTH - 1)) ? '0 : rd_ptr_q + AW'(1);
    end
  end

  // registered full and empty flags
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      cnt_q <= '0;
      in_ready_o <= 1'b1;
      out_valid_o <= 1'b0;
    end
    else
    begin
      cnt_q <= cnt_d;
      in_ready_o <= (cnt_d != CW'(DEPTH));
      out_valid_o <= (cnt_d != '0);
    end
  end

  assign out_data_o = mem_q[rd_ptr_q];
endmodule : spc_fifo

// ==========================================================
// top of the serial port control block
module spc_serial_port_ctrl #(
  parameter int FIFO_DEPTH = 8
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic [spc_pkg::REG_AW-1:0] reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic reg_we_i,
  input wire logic reg_re_i,
  output logic [15:0] reg_rdata_o,
  input wire logic tx_valid_i,
  input wire logic [spc_pkg::WORD_MAX-1:0] tx_data_i,
  output logic tx_ready_o,
  output logic [spc_pkg::WORD_MAX-1:0] rx_word_o,
  output logic rx_valid_o,
  input wire spc_pkg::spc_pin_in_s pins_i,
  output spc_pkg::spc_pin_out_s pins_o
);
  import spc_pkg::*;

  typedef enum logic [1:0] {TX_IDLE, TX_ARMED, TX_SHIFT} spc_tx_state_e;
  typedef enum logic {RX_IDLE, RX_SHIFT} spc_rx_state_e;

  // ==========================================================
  // helpers
  function automatic logic [5:0] word_bits(input logic [2:0] code);
    case (code)
      3'h0: word_bits = 6'd8;
      3'h1: word_bits = 6'd12;
      3'h2: word_bits = 6'd16;
      3'h3: word_bits = 6'd20;
      3'h4: word_bits = 6'd24;
      default: word_bits = 6'd32;
    endcase
  endfunction : word_bits

  function automatic logic chan_on(input logic [16*CHAN_EN_COUNT-1:0] flat,
                                   input logic [15:0] mc, input logic [6:0] ch);
    if (!mc[MC_MULTI_ENABLE])
      chan_on = 1'b1;
    else if (mc[MC_EXT_ENABLE])
      chan_on = flat[ch];
    else
      chan_on = flat[{2'b00, ch[4:0]}];
  endfunction : chan_on

  function automatic logic [6:0] last_word(input logic [15:0] fc);
    if (fc[FC_CLK_STOP])
      last_word = 7'h00;
    else if (fc[FC_TWO_PHASE])
      last_word = {fc[FC_WORDS_LSB+5:FC_WORDS_LSB], 1'b1};
    else
      last_word = fc[FC_WORDS_LSB+6:FC_WORDS_LSB];
  endfunction : last_word

  // ==========================================================
  // registers and state
  logic [15:0] pin_control_q;
  logic [15:0] mc_one_q;
  logic [15:0] mc_two_q;
  logic [15:0] rate_cfg_q;
  logic [15:0] frame_cfg_q;
  logic [15:0] chan_en_q [CHAN_EN_COUNT];
  logic [16*CHAN_EN_COUNT-1:0] chan_flat;
  spc_pin_in_s pin_meta_q;
  spc_pin_in_s pin_sync_q;
  spc_pin_in_s pin_prev_q;
  logic [RG_DIV_W-1:0] srg_cnt_q;
  logic srg_clk_q;
  spc_tx_state_e tx_state_q;
  logic [5:0] tx_bit_q;
  logic [6:0] tx_word_q;
  logic [WORD_MAX-1:0] tx_shreg_q;
  logic tx_oe_q;
  logic tx_fs_gen_q;
  spc_rx_state_e rx_state_q;
  logic [5:0] rx_bit_q;
  logic [6:0] rx_word_idx_q;
  logic [WORD_MAX-1:0] rx_shreg_q;
  spc_pin_out_s pins_d;

  logic ext_sel;
  logic src_sel;
  logic srg_from_rx;
  logic srg_from_tx;
  logic srg_tick;
  logic srg_wrap;
  logic clk_stop;
  logic tx_int_clk;
  logic rx_int_clk;
  logic tx_eff;
  logic tx_eff_prev;
  logic rx_eff;
  logic rx_eff_prev;
  logic tx_launch;
  logic tx_capture;
  logic rx_capture;
  logic tx_fs_ext;
  logic rx_fs_act;
  logic tx_en;
  logic rx_en;
  logic [5:0] bits;
  logic [6:0] tx_last;
  logic fifo_valid;
  logic [WORD_MAX-1:0] fifo_data;
  logic fifo_pop;
  logic tx_load;
  logic tx_load_on;
  logic [WORD_MAX-1:0] rx_next;

  // ==========================================================
  // pin synchronisers, two flops before any use
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      pin_meta_q <= '0;
      pin_sync_q <= '0;
      pin_prev_q <= '0;
    end
    else
    begin
      pin_meta_q <= pins_i;
      pin_sync_q <= pin_meta_q;
      pin_prev_q <= pin_sync_q;
    end
  end

  // ==========================================================
  // register writes
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      pin_control_q <= PIN_CONTROL_RESET;
      mc_one_q <= MC_RESET;
      mc_two_q <= MC_RESET;
      rate_cfg_q <= RATE_CFG_RESET;
      frame_cfg_q <= FRAME_CFG_RESET;
      for (int i = 0; i < CHAN_EN_COUNT; i++)
        chan_en_q[i] <= CHAN_EN_RESET;
    end
    else if (reg_we_i)
    begin
      if (reg_addr_i == ADDR_PIN_CONTROL)
        pin_control_q <= reg_wdata_i & PIN_CONTROL_MASK;
      else if (reg_addr_i == ADDR_MC_ONE)
        mc_one_q <= reg_wdata_i & MC_MASK;
      else if (reg_addr_i == ADDR_MC_TWO)
        mc_two_q <= reg_wdata_i & MC_MASK;
      else if (reg_addr_i == ADDR_RATE_CFG_TWO)
        rate_cfg_q <= reg_wdata_i & RATE_CFG_MASK;
      else if (reg_addr_i == ADDR_FRAME_CFG)
        frame_cfg_q <= reg_wdata_i & FRAME_CFG_MASK;
      else if (reg_addr_i >= ADDR_CHAN_EN_BASE &&
               reg_addr_i < ADDR_CHAN_EN_BASE + REG_AW'(CHAN_EN_COUNT))
        chan_en_q[4'(reg_addr_i - ADDR_CHAN_EN_BASE)] <= reg_wdata_i;
    end
  end

  // reads, dx and dr status bits live, clks status reads zero
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
      reg_rdata_o <= 16'h0000;
    else if (reg_re_i)
    begin
      if (reg_addr_i == ADDR_PIN_CONTROL)
      begin
        reg_rdata_o <= pin_control_q;
        reg_rdata_o[PC_CLKS_STATE] <= 1'b0;
        reg_rdata_o[PC_DX_STATE] <= pins_o.tx_data;
        reg_rdata_o[PC_DR_STATE] <= pin_sync_q.rx_data;
      end
      else if (reg_addr_i == ADDR_MC_ONE)
        reg_rdata_o <= mc_one_q;
      else if (reg_addr_i == ADDR_MC_TWO)
        reg_rdata_o <= mc_two_q;
      else if (reg_addr_i == ADDR_RATE_CFG_TWO)
        reg_rdata_o <= rate_cfg_q;
      else if (reg_addr_i == ADDR_FRAME_CFG)
        reg_rdata_o <= frame_cfg_q;
      else if (reg_addr_i >= ADDR_CHAN_EN_BASE &&
               reg_addr_i < ADDR_CHAN_EN_BASE + REG_AW'(CHAN_EN_COUNT))
        reg_rdata_o <= chan_en_q[4'(reg_addr_i - ADDR_CHAN_EN_BASE)];
      else
        reg_rdata_o <= 16'h0000;
    end
  end

  // flatten the shared enable bank
  always_comb
  begin
    for (int i = 0; i < CHAN_EN_COUNT; i++)
      chan_flat[16*i +: 16] = chan_en_q[i];
  end

  // ==========================================================
  // rate generator input mux and divider
  assign ext_sel = pin_control_q[PC_SRC_EXTEND];
  assign src_sel = rate_cfg_q[RG_SRC_SELECT];
  assign srg_from_rx = ext_sel & ~src_sel;
  assign srg_from_tx = ext_sel & src_sel;
  // sampled pin edges work at any slow rate
  always_comb
  begin
    if (!ext_sel)
      srg_tick = src_sel;
    else if (srg_from_rx)
      srg_tick = pin_sync_q.rx_bit_clock_pin & ~pin_prev_q.rx_bit_clock_pin;
    else
      srg_tick = pin_sync_q.tx_bit_clock_pin & ~pin_prev_q.tx_bit_clock_pin;
  end
  assign srg_wrap = srg_tick & (srg_cnt_q == rate_cfg_q[RG_DIV_W-1:0]);

  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      srg_cnt_q <= '0;
      srg_clk_q <= 1'b0;
    end
    else if (srg_wrap)
    begin
      srg_cnt_q <= '0;
      srg_clk_q <= ~srg_clk_q;
    end
    else if (srg_tick)
      srg_cnt_q <= srg_cnt_q + RG_DIV_W'(1);
  end

  // ==========================================================
  // bit clock selection with polarity
  assign clk_stop = frame_cfg_q[FC_CLK_STOP];
  assign tx_int_clk = pin_control_q[PC_TX_CLK_DIR] & ~srg_from_tx;
  assign rx_int_clk = pin_control_q[PC_RX_CLK_DIR] & ~srg_from_rx;
  assign tx_eff = pin_sync_q.tx_bit_clock_pin ^ pin_control_q[PC_TX_CLK_POL];
  assign tx_eff_prev = pin_prev_q.tx_bit_clock_pin ^ pin_control_q[PC_TX_CLK_POL];
  assign rx_eff = pin_sync_q.rx_bit_clock_pin ^ pin_control_q[PC_RX_CLK_POL];
  assign rx_eff_prev = pin_prev_q.rx_bit_clock_pin ^ pin_control_q[PC_RX_CLK_POL];
  assign tx_launch = tx_int_clk ? (srg_wrap & srg_clk_q) : (tx_eff_prev & ~tx_eff);
  assign tx_capture = tx_int_clk ? (srg_wrap & ~srg_clk_q) : (~tx_eff_prev & tx_eff);
  always_comb
  begin
    if (clk_stop)
      rx_capture = tx_capture;
    else if (rx_int_clk)
      rx_capture = srg_wrap & ~srg_clk_q;
    else
      rx_capture = ~rx_eff_prev & rx_eff;
  end

  // frame sync sources
  assign tx_fs_ext = pin_sync_q.tx_fs ^ pin_control_q[PC_TX_FS_POL];
  always_comb
  begin
    if (clk_stop)
      rx_fs_act = pin_control_q[PC_TX_FS_DIR] ? tx_fs_gen_q : tx_fs_ext;
    else if (pin_control_q[PC_RX_FS_DIR])
      rx_fs_act = tx_fs_gen_q;
    else
      rx_fs_act = pin_sync_q.rx_fs ^ pin_control_q[PC_RX_FS_POL];
  end

  assign bits = word_bits(frame_cfg_q[FC_WL_LSB+2:FC_WL_LSB]);
  assign tx_last = last_word(frame_cfg_q);
  assign tx_en = frame_cfg_q[FC_TX_EN];
  assign rx_en = frame_cfg_q[FC_RX_EN] & ~pin_control_q[PC_RX_GPIO_EN];

  // ==========================================================
  // transmit fifo
  spc_fifo #(
    .WIDTH(WORD_MAX),
    .DEPTH(FIFO_DEPTH)
  ) u_tx_fifo (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .in_valid_i(tx_valid_i),
    .in_data_i(tx_data_i),
    .in_ready_o(tx_ready_o),
    .out_valid_o(fifo_valid),
    .out_data_o(fifo_data),
    .out_ready_i(fifo_pop)
  );

  // word load points and channel check
  always_comb
  begin
    tx_load = 1'b0;
    if (tx_launch && tx_state_q == TX_ARMED)
      tx_load = 1'b1;
    else if (tx_launch && tx_state_q == TX_SHIFT && tx_bit_q == 6'd0 && tx_word_q != tx_last)
      tx_load = 1'b1;
  end
  assign tx_load_on = chan_on(chan_flat, mc_two_q, (tx_state_q == TX_ARMED) ? 7'h00 :
                              tx_word_q + 7'h01);
  assign fifo_pop = tx_load & tx_load_on & fifo_valid;

  // ==========================================================
  // transmit framing and shifting
  always_ff @(posedge mclk_i)
  begin
    if (rst_i || !tx_en)
    begin
      tx_state_q <= TX_IDLE;
      tx_bit_q <= '0;
      tx_word_q <= '0;
      tx_shreg_q <= '0;
      tx_oe_q <= 1'b0;
      tx_fs_gen_q <= 1'b0;
    end
    else
    begin
      case (tx_state_q)
        TX_IDLE:
        begin
          if (pin_control_q[PC_TX_FS_DIR] && tx_launch && fifo_valid)
          begin
            tx_fs_gen_q <= 1'b1;
            tx_state_q <= TX_ARMED;
          end
          else if (!pin_control_q[PC_TX_FS_DIR] && tx_capture && tx_fs_ext)
            tx_state_q <= TX_ARMED;
        end
        TX_ARMED, TX_SHIFT:
        begin
          if (tx_launch)
          begin
            tx_fs_gen_q <= 1'b0;
            if (tx_load)
            begin
              // left-align word, disabled channel releases pin
              tx_state_q <= TX_SHIFT;
              tx_bit_q <= bits - 6'd1;
              tx_word_q <= (tx_state_q == TX_ARMED) ? 7'h00 : tx_word_q + 7'h01;
              tx_oe_q <= tx_load_on;
              tx_shreg_q <= fifo_valid ? (fifo_data << (6'd32 - bits)) : '0;
            end
            else if (tx_bit_q != 6'd0)
            begin
              tx_bit_q <= tx_bit_q - 6'd1;
              tx_shreg_q <= {tx_shreg_q[WORD_MAX-2:0], 1'b0};
            end
            else
            begin
              tx_state_q <= TX_IDLE;
              tx_oe_q <= 1'b0;
            end
          end
        end
        default: tx_state_q <= TX_IDLE;
      endcase
    end
  end

  // ==========================================================
  // receive framing and shifting
  assign rx_next = {rx_shreg_q[WORD_MAX-2:0], pin_sync_q.rx_data};
  always_ff @(posedge mclk_i)
  begin
    if (rst_i || !rx_en)
    begin
      rx_state_q <= RX_IDLE;
      rx_bit_q <= '0;
      rx_word_idx_q <= '0;
      rx_shreg_q <= '0;
      rx_word_o <= '0;
      rx_valid_o <= 1'b0;
    end
    else
    begin
      rx_valid_o <= 1'b0;
      if (rx_capture)
      begin
        case (rx_state_q)
          RX_IDLE:
          begin
            if (rx_fs_act)
            begin
              rx_state_q <= RX_SHIFT;
              rx_bit_q <= bits - 6'd1;
              rx_word_idx_q <= '0;
              rx_shreg_q <= '0;
            end
          end
          RX_SHIFT:
          begin
            if (rx_bit_q != 6'd0)
            begin
              rx_bit_q <= rx_bit_q - 6'd1;
              rx_shreg_q <= rx_next;
            end
            else
            begin
              rx_shreg_q <= '0;
              if (chan_on(chan_flat, mc_one_q, rx_word_idx_q))
              begin
                rx_word_o <= rx_next;
                rx_valid_o <= 1'b1;
              end
              if (rx_word_idx_q == tx_last)
                rx_state_q <= RX_IDLE;
              else
              begin
                rx_word_idx_q <= rx_word_idx_q + 7'h01;
                rx_bit_q <= bits - 6'd1;
              end
            end
          end
          default: rx_state_q <= RX_IDLE;
        endcase
      end
    end
  end

  // ==========================================================
  // pin drivers, all registered
  always_comb
  begin
    pins_d.tx_bit_clock_pin = srg_clk_q ^ pin_control_q[PC_TX_CLK_POL];
    pins_d.tx_bit_clock_pin_oe = tx_int_clk;
    pins_d.rx_bit_clock_pin = srg_clk_q ^ pin_control_q[PC_RX_CLK_POL];
    pins_d.rx_bit_clock_pin_oe = rx_int_clk & ~clk_stop &
                                 ~pin_control_q[PC_RX_GPIO_EN];
    pins_d.tx_fs = tx_fs_gen_q ^ pin_control_q[PC_TX_FS_POL];
    pins_d.tx_fs_oe = pin_control_q[PC_TX_FS_DIR];
    pins_d.rx_fs = tx_fs_gen_q ^ pin_control_q[PC_RX_FS_POL];
    pins_d.rx_fs_oe = pin_control_q[PC_RX_FS_DIR] & ~clk_stop &
                      ~pin_control_q[PC_RX_GPIO_EN];
    pins_d.tx_data = tx_shreg_q[WORD_MAX-1];
    pins_d.tx_data_oe = tx_oe_q;
  end

  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
      pins_o <= '0;
    else
      pins_o <= pins_d;
  end
endmodule : spc_serial_port_ctrl

`default_nettype wire

// file: tb/spc_codec_model.sv
// far-side codec model: loopback plus outside bit clock
`timescale 1ns/1ps
`default_nettype none
module spc_codec_model (
  input wire logic ext_clk_en_i,
  input wire spc_pkg::spc_pin_out_s pins_o_i,
  output spc_pkg::spc_pin_in_s pins_i_o
);
  import spc_pkg::*;
  logic ext_clk = 1'b0;
  // ==========================================================
  // outside bit clock, 80 ns, still when off
  always #40 ext_clk = ext_clk_en_i ? ~ext_clk : ext_clk;
  // ==========================================================
  // pin levels, transmit looped onto receive
  assign pins_i_o.tx_bit_clock_pin = pins_o_i.tx_bit_clock_pin_oe ? pins_o_i.tx_bit_clock_pin
                                     : ext_clk;
  assign pins_i_o.rx_bit_clock_pin = pins_o_i.rx_bit_clock_pin_oe ? pins_o_i.rx_bit_clock_pin
                                     : (ext_clk_en_i ? ext_clk : pins_o_i.tx_bit_clock_pin);
  assign pins_i_o.tx_fs = pins_o_i.tx_fs_oe ? pins_o_i.tx_fs : 1'b0;
  assign pins_i_o.rx_fs = pins_o_i.rx_fs_oe ? pins_o_i.rx_fs : pins_o_i.tx_fs;
  // released data line shows the inverse of the last level
  assign pins_i_o.rx_data = pins_o_i.tx_data_oe ? pins_o_i.tx_data : ~pins_o_i.tx_data;
endmodule : spc_codec_model
`default_nettype wire

// file: tb/spc_serial_port_ctrl_properties.sv
// port checker of the serial port control block and its bind
`timescale 1ns/1ps
`default_nettype none
module spc_ctrl_checker
  import spc_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic [spc_pkg::REG_AW-1:0] reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic reg_we_i,
  input wire logic reg_re_i,
  input wire logic [15:0] reg_rdata_o,
  input wire logic tx_ready_o,
  input wire logic rx_valid_o,
  input wire spc_pkg::spc_pin_out_s pins_o
);
  logic [15:0] pc_q, rg_q, fc_q;
  // ==========================================================
  // register shadows
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      pc_q <= PIN_CONTROL_RESET;
      rg_q <= RATE_CFG_RESET;
      fc_q <= FRAME_CFG_RESET;
    end
    else if (reg_we_i)
    begin
      if (reg_addr_i == ADDR_PIN_CONTROL) pc_q <= reg_wdata_i;
      if (reg_addr_i == ADDR_RATE_CFG_TWO) rg_q <= reg_wdata_i;
      if (reg_addr_i == ADDR_FRAME_CFG) fc_q <= reg_wdata_i;
    end
  end
  // ==========================================================
  // port properties
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  sequence s_rx_src;
    pc_q[PC_SRC_EXTEND] && !rg_q[RG_SRC_SELECT];
  endsequence
  sequence s_tx_src;
    pc_q[PC_SRC_EXTEND] && rg_q[RG_SRC_SELECT];
  endsequence
  sequence s_pc_read;
    reg_re_i && !reg_we_i && reg_addr_i == ADDR_PIN_CONTROL;
  endsequence
  property p_pc_rw;
    logic [15:0] v;
    (reg_we_i && reg_addr_i == ADDR_PIN_CONTROL, v = reg_wdata_i) ##1 !reg_we_i ##1 s_pc_read
      |=> (reg_rdata_o & 16'hFF8F) == (v & PIN_CONTROL_MASK);
  endproperty
  a_reset_quiet: assert property ($fell(rst_i) |-> pins_o == '0 && !rx_valid_o
    && reg_rdata_o == 16'h0000 && tx_ready_o) else $error("outputs not quiet after reset");
  a_rx_pulse_once: assert property (rx_valid_o |=> !rx_valid_o)
    else $error("receive valid longer than one cycle");
  a_unmapped_zero: assert property (reg_re_i && reg_addr_i == 5'h14
    |=> reg_rdata_o == 16'h0000) else $error("unmapped read not zero");
  a_rdata_holds: assert property (!reg_re_i |=> $stable(reg_rdata_o))
    else $error("read data moved without a read");
  a_pin_ctrl_rw: assert property (p_pc_rw)
    else $error("pin control read back wrong");
  a_rx_pin_released: assert property (s_rx_src [*3] |-> !pins_o.rx_bit_clock_pin_oe)
    else $error("rx bit clock driven while rate input");
  a_tx_pin_released: assert property (s_tx_src [*3] |-> !pins_o.tx_bit_clock_pin_oe)
    else $error("tx bit clock driven while rate input");
  a_gpio_rx_quiet: assert property (pc_q[PC_RX_GPIO_EN] [*3]
    |-> !pins_o.rx_bit_clock_pin_oe && !pins_o.rx_fs_oe) else $error("rx pins driven in gpio");
  a_clkstop_rx_quiet: assert property (fc_q[FC_CLK_STOP] [*3]
    |-> !pins_o.rx_bit_clock_pin_oe && !pins_o.rx_fs_oe) else $error("rx pins driven in stop");
endmodule : spc_ctrl_checker
bind spc_serial_port_ctrl spc_ctrl_checker u_chk (.mclk_i, .rst_i, .reg_addr_i,
  .reg_wdata_i, .reg_we_i, .reg_re_i, .reg_rdata_o, .tx_ready_o, .rx_valid_o, .pins_o);
`default_nettype wire

// file: tb/test_serial_port_clock_pin_control.sv
// self-checking bench for the serial port control block
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin fail_count++; \
  $display("MISMATCH %0t got %h exp %h", $time, g, e); end end
module test_serial_port_clock_pin_control;
  import spc_pkg::*;
  logic mclk_i, rst_i, reg_we_i, reg_re_i, tx_valid_i, tx_ready_o, rx_valid_o, ext_clk_en;
  logic [REG_AW-1:0] reg_addr_i;
  logic [15:0] reg_wdata_i, reg_rdata_o, rd, w;
  logic [31:0] tx_data_i, rx_word_o, tx_sh, msk, exp_w;
  logic prev_clk = 1'b0, prev_fs = 1'b0;
  spc_pin_in_s pins_i;
  spc_pin_out_s pins_o;
  logic [15:0] shadow [0:31];
  logic [31:0] txq [$], rxq [$];
  int fail_count = 0, cmp_count = 0, seed = 28303, cycles = 0, wl = 8, cnt = 0, n;
  spc_serial_port_ctrl #(.FIFO_DEPTH(8)) dut (.mclk_i, .rst_i, .reg_addr_i, .reg_wdata_i,
    .reg_we_i, .reg_re_i, .reg_rdata_o, .tx_valid_i, .tx_data_i, .tx_ready_o, .rx_word_o,
    .rx_valid_o, .pins_i, .pins_o);
  spc_codec_model partner (.ext_clk_en_i(ext_clk_en), .pins_o_i(pins_o), .pins_i_o(pins_i));
  // ==========================================================
  // clock, hang limit and verdict
  initial
  begin
    mclk_i = 0;
    forever #4 mclk_i = ~mclk_i;
  end
  always @(posedge mclk_i)
  begin
    cycles++;
    if (cycles == 60000)
    begin
      fail_count++;
      finish_test();
    end
  end
  task finish_test;
    if (fail_count == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : finish_test
  // ==========================================================
  // bus tasks and register masks
  task wrreg(input logic [4:0] a, input logic [15:0] d);
    @(posedge mclk_i);
    #1 reg_addr_i = a;
    reg_wdata_i = d;
    reg_we_i = 1;
    @(posedge mclk_i);
    #1 reg_we_i = 0;
  endtask : wrreg
  task rdreg(input logic [4:0] a);
    @(posedge mclk_i);
    #1 reg_addr_i = a;
    reg_re_i = 1;
    @(posedge mclk_i);
    #1 reg_re_i = 0;
    @(posedge mclk_i);
    #1 rd = reg_rdata_o;
  endtask : rdreg
  // push until refused
  task fill(output int k);
    k = 0;
    @(posedge mclk_i);
    #1 tx_valid_i = 1;
    tx_data_i = $random(seed);
    for (int i = 0; i < 20; i++)
    begin
      @(posedge mclk_i);
      if (tx_ready_o !== 1'b1) break;
      txq.push_back(tx_data_i);
      rxq.push_back(tx_data_i);
      k++;
      #1 tx_data_i = $random(seed);
    end
    #1 tx_valid_i = 0;
  endtask : fill
  function automatic logic [15:0] wmask(input int a);
    case (a)
      0: return PIN_CONTROL_MASK;
      1, 2: return MC_MASK;
      3: return RATE_CFG_MASK;
      4: return FRAME_CFG_MASK;
      default: return (a >= 8 && a < 8 + CHAN_EN_COUNT) ? 16'hFFFF : 16'h0000;
    endcase
  endfunction : wmask
  // ==========================================================
  // transmit pin capture and received word check
  always @(posedge mclk_i)
  begin
    msk = 32'((64'd1 << wl) - 64'd1);
    if (pins_o.tx_fs && !prev_fs) cnt = 0;
    if (pins_o.tx_bit_clock_pin && !prev_clk && pins_o.tx_data_oe)
    begin
      tx_sh = {tx_sh[30:0], pins_o.tx_data};
      cnt++;
      if (cnt == wl && txq.size() > 0)
      begin
        exp_w = txq.pop_front();
        `CHK(tx_sh & msk, exp_w & msk)
      end
    end
    if (rx_valid_o === 1'b1 && rxq.size() > 0)
    begin
      exp_w = rxq.pop_front();
      `CHK(rx_word_o & msk, exp_w & msk)
    end
    prev_clk = pins_o.tx_bit_clock_pin;
    prev_fs = pins_o.tx_fs;
  end
  // ==========================================================
  // main sequence
  initial
  begin
    rst_i = 1;
    reg_we_i = 0;
    reg_re_i = 0;
    tx_valid_i = 0;
    ext_clk_en = 0;
    reg_addr_i = '0;
    reg_wdata_i = '0;
    tx_data_i = '0;
    repeat (20) @(posedge mclk_i);
    #1 rst_i = 0;
    // reset values, then random write and read back
    for (int a = 0; a < 32; a++) shadow[a] = 16'h0000;
    shadow[ADDR_RATE_CFG_TWO] = RATE_CFG_RESET;
    for (int p = 0; p < 3; p++)
    begin
      for (int a = 0; a < 21; a++)
      begin
        rdreg(5'(a));
        `CHK(rd & (a == 0 ? 16'hFF8F : 16'hFFFF), shadow[a])
      end
      for (int a = 0; a < 21; a++)
      begin
        w = 16'($random(seed));
        wrreg(5'(a), w);
        shadow[a] = w & wmask(a);
      end
    end
    // each word length: fill fifo, drain over loopback
    wrreg(ADDR_MC_ONE, 16'h0000);
    wrreg(ADDR_MC_TWO, 16'h0000);
    wrreg(ADDR_RATE_CFG_TWO, 16'h2007);
    wrreg(ADDR_PIN_CONTROL, 16'h0A00);
    for (int c = 0; c < 6; c++)
    begin
      wrreg(ADDR_FRAME_CFG, 16'(c));
      wl = (c == 5) ? 32 : 8 + 4 * c;
      fill(n);
      `CHK(n, 8)
      wrreg(ADDR_FRAME_CFG, 16'h3000 | 16'(c));
      for (int t = 0; t < 6000 && txq.size() + rxq.size() > 0; t++) @(posedge mclk_i);
      `CHK(txq.size() + rxq.size(), 0)
      `CHK(tx_ready_o, 1'b1)
    end
    // bit-clock pin as rate input loses its driver
    wrreg(ADDR_FRAME_CFG, 16'h0000);
    ext_clk_en = 1;
    for (int s = 0; s < 2; s++)
    begin
      wrreg(ADDR_RATE_CFG_TWO, s ? 16'h2000 : 16'h0000);
      wrreg(ADDR_PIN_CONTROL, 16'h0380);
      rdreg(ADDR_PIN_CONTROL);
      `CHK(rd & 16'hFF8F, 16'h0380)
      repeat (8) @(posedge mclk_i);
      `CHK(pins_o.rx_bit_clock_pin_oe, 1'(s))
      `CHK(pins_o.tx_bit_clock_pin_oe, 1'(1 - s))
    end
    finish_test();
  end
endmodule : test_serial_port_clock_pin_control
`default_nettype wire
